// *** psi_special_image.sv ***
`timescale 1ns/100ps
module psi_special_image
  import psi_pkg::*;
#(
  parameter int HOLD_MAX = 512
) (
  input  wire logic        clk,            // PCI clock.
  input  wire logic        reset_n,        // Asynchronous reset, active low.
  input  wire logic        clk_en,         // Freezes all state while low.
  input  wire logic [11:0] reg_addr,       // Register byte address.
  input  wire logic [31:0] reg_wdata,      // Register write data.
  input  wire logic        reg_wr,         // Register write strobe.
  input  wire logic        reg_rd,         // Register read strobe.
  output logic      [31:0] reg_rdata,      // Read data, one cycle after strobe.
  input  wire logic        addr_valid,     // PCI address phase strobe.
  input  wire logic [31:0] pci_addr,       // PCI address.
  input  wire logic [2:0]  pci_cmd_space,  // Command space, memory or I/O.
  input  wire logic        pci_write,      // Access is a write.
  input  wire logic        other_hit,      // Another target image claims it.
  input  wire logic        coupled_done,   // A coupled transaction completed.
  output psi_xlate_t       xlate,          // Registered decode result.
  output logic             need_arb,       // Claimed coupled access must arbitrate.
  output logic             vme_held        // VMEbus held by the slave channel.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Sizing. The hold counter is as wide as HOLD_MAX needs and no wider.
  localparam int CNT_W   = $clog2(HOLD_MAX + 1);
  localparam int REGIONS = 4;

  // The select decode reaches 512 clocks, so a smaller counter would wrap.
  if (HOLD_MAX < 512) begin : g_hold_too_small
    $error("HOLD_MAX must be at least 512");
  end

  if (CNT_W > 16) begin : g_hold_too_large
    $error("HOLD_MAX must fit a 16-bit counter");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register fields, each held in its own flip-flops.
  logic [3:0]              compat_q;       // Legacy field, stored only.
  logic [2:0]              hold_sel_q;     // Hold time select.
  logic                    img_en_q;       // Image enable.
  logic                    post_en_q;      // Posted write enable.
  logic [REGIONS-1:0]      wide_q;         // Per-region 32-bit port.
  logic [REGIONS-1:0]      prog_q;         // Per-region program modifier.
  logic [REGIONS-1:0]      super_q;        // Per-region supervisor modifier.
  logic [5:0]              base_q;         // Image base, address bits 31:26.
  logic                    space_q;        // 1 for I/O space.

  // Hold state.
  logic [CNT_W-1:0]        hold_cnt_q;     // Clocks left in the hold.
  logic                    held_q;         // Hold running.
  logic [CNT_W-1:0]        hold_load;      // Count loaded on completion.
  logic                    hold_armed;     // Selected hold is not zero.

  // Register access decode.
  logic                    misc_sel;       // Address hits the misc register.
  logic                    spec_sel;       // Address hits the image register.
  logic [31:0]             misc_view;      // Misc register as software sees it.
  logic [31:0]             spec_view;      // Image register as software sees it.

  // Access decode.
  logic                    base_match;     // Top six address bits hit.
  logic                    space_match;    // Command is in the chosen space.
  logic                    claim;          // Image claims the access.
  logic                    a16;            // Access falls in the A16 window.
  logic [1:0]              region;         // Region number.
  logic [5:0]              am;             // Address modifier for the access.
  logic                    wide32;         // Region allows 32-bit port.
  logic                    posted;         // Write may be posted.

  // Per-region attribute tables.
  wire  [REGIONS-1:0][5:0] region_am_a16;  // A16 modifier per region.
  wire  [REGIONS-1:0][5:0] region_am_a24;  // A24 modifier per region.

  // Decode result flip-flops.
  logic                    hit_q;          // Registered claim.
  logic [1:0]              region_q;       // Registered region.
  logic                    a16_q;          // Registered A16 flag.
  logic                    wide32_q;       // Registered width.
  logic [5:0]              am_q;           // Registered modifier.
  logic                    posted_q;       // Registered posting.
  logic [23:0]             vme_addr_q;     // Registered VMEbus address.

  ////////////////////////////////////////////////////////////////////////////////
  // Hold select decode; reserved code 111 behaves like release at once.
  function automatic logic [CNT_W-1:0] hold_clocks(input logic [2:0] sel);
    logic [CNT_W-1:0] n;
    n = '0;
    if (sel != 3'h0 && sel != 3'h7) begin
      n = CNT_W'(PSI_HOLD_MIN << (sel - 3'h1));
    end
    return n;
  endfunction

  // Only single-cycle codes are listed here, never the block ones.
  function automatic logic [5:0] a24_code(input logic sup, input logic prog);
    logic [5:0] c;
    c = PSI_AM_A24_UDATA;
    case ({sup, prog})
      2'b00: begin
        c = PSI_AM_A24_UDATA;
      end
      2'b01: begin
        c = PSI_AM_A24_UPROG;
      end
      2'b10: begin
        c = PSI_AM_A24_SDATA;
      end
      default: begin
        c = PSI_AM_A24_SPROG;
      end
    endcase
    return c;
  endfunction

  // The program bit has no say in the short window.
  function automatic logic [5:0] a16_code(input logic sup);
    logic [5:0] c;
    c = sup ? PSI_AM_A16_SUP : PSI_AM_A16_USER;
    return c;
  endfunction

  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
    logic h;
    h = (addr == offset);
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register access.
  assign misc_sel = reg_hit(reg_addr, PSI_MISC_OFFSET);
  assign spec_sel = reg_hit(reg_addr, PSI_SPEC_OFFSET);

  // Reserved bits are never stored, so they read back as zero.
  assign misc_view = {compat_q, 1'b0, hold_sel_q, 24'h000000} & PSI_MISC_WMASK;
  assign spec_view = {img_en_q, post_en_q, 6'h00, wide_q, 4'h0, prog_q, super_q, base_q, 1'b0, space_q}
                     & PSI_SPEC_WMASK;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compat_q <= PSI_MISC_RESET[PSI_COMPAT_LSB +: 4];
    end else if (clk_en && reg_wr && misc_sel) begin
      compat_q <= reg_wdata[PSI_COMPAT_LSB +: 4];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_sel_q <= PSI_MISC_RESET[PSI_HOLD_LSB +: 3];
    end else if (clk_en && reg_wr && misc_sel) begin
      hold_sel_q <= reg_wdata[PSI_HOLD_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      img_en_q <= PSI_SPEC_RESET[PSI_EN_BIT];
    end else if (clk_en && reg_wr && spec_sel) begin
      img_en_q <= reg_wdata[PSI_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      post_en_q <= PSI_SPEC_RESET[PSI_POST_BIT];
    end else if (clk_en && reg_wr && spec_sel) begin
      post_en_q <= reg_wdata[PSI_POST_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wide_q <= PSI_SPEC_RESET[PSI_WIDE_LSB +: REGIONS];
    end else if (clk_en && reg_wr && spec_sel) begin
      wide_q <= reg_wdata[PSI_WIDE_LSB +: REGIONS];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_q <= PSI_SPEC_RESET[PSI_PROG_LSB +: REGIONS];
    end else if (clk_en && reg_wr && spec_sel) begin
      prog_q <= reg_wdata[PSI_PROG_LSB +: REGIONS];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      super_q <= PSI_SPEC_RESET[PSI_SUPER_LSB +: REGIONS];
    end else if (clk_en && reg_wr && spec_sel) begin
      super_q <= reg_wdata[PSI_SUPER_LSB +: REGIONS];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= PSI_SPEC_RESET[PSI_BASE_LSB +: 6];
    end else if (clk_en && reg_wr && spec_sel) begin
      base_q <= reg_wdata[PSI_BASE_LSB +: 6];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      space_q <= PSI_SPEC_RESET[PSI_SPACE_BIT];
    end else if (clk_en && reg_wr && spec_sel) begin
      space_q <= reg_wdata[PSI_SPACE_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      if (reg_rd && misc_sel) begin
        reg_rdata <= misc_view;
      end else if (reg_rd && spec_sel) begin
        reg_rdata <= spec_view;
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-region modifier tables; the lowest region sits at the lowest address.
  for (genvar g = 0; g < REGIONS; g++) begin : g_region
    assign region_am_a16[g] = a16_code(super_q[g]);
    assign region_am_a24[g] = a24_code(super_q[g], prog_q[g]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode. The image is 64 Mbyte aligned, so only the top six bits compare.
  always_comb begin
    region      = pci_addr[25:24];
    a16         = (pci_addr[23:16] == PSI_A16_TOP);
    base_match  = (pci_addr[31:26] == base_q);
    space_match = (pci_cmd_space == (space_q ? PSI_CMD_IO : PSI_CMD_MEM));
    claim       = addr_valid && img_en_q && base_match && space_match
                  && !other_hit;
    am          = a16 ? region_am_a16[region] : region_am_a24[region];
    wide32      = wide_q[region];
    // I/O space never posts, whatever the posting bit says.
    posted      = pci_write && post_en_q && !space_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode result, one concern per process.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hit_q    <= 1'b0;
      posted_q <= 1'b0;
    end else if (clk_en) begin
      hit_q    <= claim;
      posted_q <= claim && posted;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      region_q   <= 2'h0;
      a16_q      <= 1'b0;
      vme_addr_q <= 24'h000000;
    end else if (clk_en) begin
      region_q   <= region;
      a16_q      <= a16;
      vme_addr_q <= pci_addr[23:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wide32_q <= 1'b0;
      am_q     <= 6'h00;
    end else if (clk_en) begin
      wide32_q <= wide32;
      am_q     <= am;
    end
  end

  // A coupled access inside a running hold reuses the bus it already owns.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      need_arb <= 1'b0;
    end else if (clk_en) begin
      need_arb <= claim && !posted && !held_q;
    end
  end

  assign xlate.hit      = hit_q;
  assign xlate.region   = region_q;
  assign xlate.a16      = a16_q;
  assign xlate.wide32   = wide32_q;
  assign xlate.am       = am_q;
  assign xlate.posted   = posted_q;
  assign xlate.vme_addr = vme_addr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Hold timer. Changing the select mid-hold is left to software discipline.
  always_comb begin
    hold_load  = hold_clocks(hold_sel_q);
    hold_armed = (hold_load != '0);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_q <= '0;
    end else if (clk_en) begin
      if (coupled_done) begin
        hold_cnt_q <= hold_load;
      end else if (hold_cnt_q > CNT_W'(1)) begin
        hold_cnt_q <= hold_cnt_q - CNT_W'(1);
      end else begin
        hold_cnt_q <= '0;
      end
    end
  end

  // A fresh completion wins over an expiry in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_q <= 1'b0;
    end else if (clk_en) begin
      if (coupled_done) begin
        held_q <= hold_armed;
      end else if (hold_cnt_q <= CNT_W'(1)) begin
        held_q <= 1'b0;
      end
    end
  end

  // With a zero select the bus is still shown held for the completing cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vme_held <= 1'b0;
    end else if (clk_en) begin
      vme_held <= held_q || coupled_done;
    end
  end

endmodule

// *** psi_pkg.sv ***
package psi_pkg;

  localparam logic [11:0] PSI_MISC_OFFSET   = 12'h184;
  localparam logic [11:0] PSI_SPEC_OFFSET   = 12'h188;
  localparam logic [31:0] PSI_MISC_RESET    = 32'h00000000;
  localparam logic [31:0] PSI_SPEC_RESET    = 32'h00000000;
  localparam logic [31:0] PSI_MISC_WMASK    = 32'hF7000000;
  localparam logic [31:0] PSI_SPEC_WMASK    = 32'hC0F0FFFD;

  localparam int PSI_COMPAT_LSB  = 28;
  localparam int PSI_HOLD_LSB    = 24;
  localparam int PSI_EN_BIT      = 31;
  localparam int PSI_POST_BIT    = 30;
  localparam int PSI_WIDE_LSB    = 20;
  localparam int PSI_PROG_LSB    = 12;
  localparam int PSI_SUPER_LSB   = 8;
  localparam int PSI_BASE_LSB    = 2;
  localparam int PSI_SPACE_BIT   = 0;

  localparam int PSI_CLK_MHZ     = 100;
  localparam int PSI_HOLD_MIN    = 16;
  localparam logic [7:0] PSI_A16_TOP = 8'hFF;

  localparam logic [2:0] PSI_CMD_IO   = 3'h1;
  localparam logic [2:0] PSI_CMD_MEM  = 3'h3;

  // Address modifier codes without block transfer variants.
  localparam logic [5:0] PSI_AM_A16_USER  = 6'h29;
  localparam logic [5:0] PSI_AM_A16_SUP   = 6'h2D;
  localparam logic [5:0] PSI_AM_A24_UDATA = 6'h39;
  localparam logic [5:0] PSI_AM_A24_UPROG = 6'h3A;
  localparam logic [5:0] PSI_AM_A24_SDATA = 6'h3D;
  localparam logic [5:0] PSI_AM_A24_SPROG = 6'h3E;

  typedef struct packed {
    logic        hit;
    logic [1:0]  region;
    logic        a16;
    logic        wide32;
    logic [5:0]  am;
    logic        posted;
    logic [23:0] vme_addr;
  } psi_xlate_t;

endpackage

// *** psi_vme_partner.sv ***
`timescale 1ns/100ps
module psi_vme_partner
  import psi_pkg::*;
#(
  parameter int LAT = 2
) (
  input  wire logic       clk,           // Clock.
  input  wire logic       reset_n,       // Reset, active low.
  input  wire logic       kick,          // Bench-ordered completion.
  input  wire psi_xlate_t xlate,         // Decode result.
  output logic            coupled_done   // Completion pulse.
);
  logic [LAT-1:0] dly_q;
  // Every claimed coupled access completes LAT cycles later, as a real slave would.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) dly_q <= '0;
    else dly_q <= {dly_q[LAT-2:0], kick | (xlate.hit & ~xlate.posted)};
  end
  assign coupled_done = dly_q[LAT-1];
endmodule

// *** psi_special_image_assertions.sv ***
`timescale 1ns/100ps
module psi_checker
  import psi_pkg::*;
(
  input wire logic        clk,         // Clock.
  input wire logic        reset_n,     // Reset.
  input wire logic        clk_en,      // Enable.
  input wire logic        addr_valid,  // Address phase.
  input wire logic [31:0] pci_addr,    // Address.
  input wire logic        other_hit,   // Other image.
  input wire psi_xlate_t  xlate,       // Decode.
  input wire logic        need_arb,    // Arbitrate.
  input wire logic        vme_held     // Bus held.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic av = addr_valid & clk_en;
  AST_OTHER: assert property (av && other_hit |=> !xlate.hit) else $error("claimed over other image");
  AST_REGION: assert property (av |=> !xlate.hit || xlate.region == $past(pci_addr[25:24])) else $error("region");
  AST_A16: assert property (av |=> !xlate.hit || xlate.a16 == ($past(pci_addr[23:16]) == 8'hFF)) else $error("a16");
  AST_VADDR: assert property (av |=> !xlate.hit || xlate.vme_addr == $past(pci_addr[23:0])) else $error("vme addr");
  AST_NOBLT: assert property (xlate.hit |-> xlate.am inside {6'h29, 6'h2D, 6'h39, 6'h3A, 6'h3D, 6'h3E}) else $error("am");
  AST_A16AM: assert property (xlate.hit && xlate.a16 |-> xlate.am inside {6'h29, 6'h2D}) else $error("a16 am");
  AST_RELEASE: assert property ($fell(vme_held) && $past(vme_held, 2) |-> $past(vme_held, 16))
    else $error("hold too short");
  AST_NOARB: assert property (av && vme_held && $past(vme_held) && $past(vme_held, 2) |=> !need_arb)
    else $error("arbitrated while held");
endmodule
bind psi_special_image psi_checker u_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .addr_valid(addr_valid),
  .pci_addr(pci_addr), .other_hit(other_hit), .xlate(xlate), .need_arb(need_arb), .vme_held(vme_held));

// *** psi_special_image_bench.sv ***
`timescale 1ns/100ps
module psi_special_image_bench;
  import psi_pkg::*;
  logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, addr_valid = 0, pci_write = 0, other_hit = 0, kick = 0;
  logic clk_en = 1;
  logic [3:0]  wd = 4'h5, pg = 4'h3, sp = 4'h9;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, pci_addr = '0, reg_rdata;
  logic [2:0]  pci_cmd_space = '0;
  logic        need_arb, vme_held, coupled_done;
  psi_xlate_t  xlate, exp;
  int          mismatches = 0, num_checks = 0, n;
  initial forever #5 clk = ~clk;
  psi_special_image u_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_valid(addr_valid), .pci_addr(pci_addr),
    .pci_cmd_space(pci_cmd_space), .pci_write(pci_write), .other_hit(other_hit), .coupled_done(coupled_done),
    .xlate(xlate), .need_arb(need_arb), .vme_held(vme_held));
  psi_vme_partner u_vme (.clk(clk), .reset_n(reset_n), .kick(kick), .xlate(xlate), .coupled_done(coupled_done));
  task automatic chk(string name, logic [35:0] seen, logic [35:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rdc(logic [11:0] a, logic [31:0] want);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk("reg", reg_rdata, want);
  endtask
  task automatic acc(logic [31:0] a, logic [2:0] c, logic w, logic o);
    @(posedge clk) {addr_valid, pci_addr, pci_cmd_space, pci_write, other_hit} <= {1'b1, a, c, w, o};
    @(posedge clk) addr_valid <= 1'b0;
    #1;
  endtask
  // Ends on the edge at which the design samples the completion.
  task automatic fire();
    @(posedge clk) kick <= 1'b1;
    @(posedge clk) kick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic hold_len(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1 k += vme_held;
    end while (vme_held === 1'b1 && k < 600);
  endtask
  function automatic logic [5:0] amf(logic a16, logic s, logic p);
    return a16 ? (s ? PSI_AM_A16_SUP : PSI_AM_A16_USER) : s ? (p ? PSI_AM_A24_SPROG : PSI_AM_A24_SDATA)
                                                            : (p ? PSI_AM_A24_UPROG : PSI_AM_A24_UDATA);
  endfunction
  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rdc(PSI_MISC_OFFSET, PSI_MISC_RESET);
    rdc(PSI_SPEC_OFFSET, PSI_SPEC_RESET);
    rdc(12'h000, 32'h00000000);
    wr(PSI_MISC_OFFSET, 32'hFFFFFFFF);
    rdc(PSI_MISC_OFFSET, 32'hF7000000);
    wr(PSI_SPEC_OFFSET, 32'hFFFFFFFF);
    rdc(PSI_SPEC_OFFSET, 32'hC0F0FFFD);
    wr(PSI_SPEC_OFFSET, 32'h00000000);
    for (int c = 6; c > 0; c--) begin
      wr(PSI_MISC_OFFSET, 32'hF0000000 | (32'(c) << 24));
      fire();
      hold_len(n);
      chk("hold", n, 16 << (c - 1));
    end
    wr(PSI_SPEC_OFFSET, 32'hC05039A8);
    for (int i = 0; i < 8; i++) begin
      exp = '{1'b1, 2'(i >> 1), i[0], wd[i >> 1], amf(i[0], sp[i >> 1], pg[i >> 1]),
              1'b1, {i[0] ? 8'hFF : 8'h12, 8'h34, 8'h56}};
      acc({6'h2A, 2'(i >> 1), exp.vme_addr[23:0]}, PSI_CMD_MEM, 1'b1, 1'b0);
      chk("xlate", xlate, exp);
    end
    fire();
    repeat (2) @(posedge clk);
    acc(32'hA8000000, PSI_CMD_MEM, 1'b0, 1'b0);
    chk("arb", {xlate.hit, need_arb}, 2'b10);
    fire();
    hold_len(n);
    chk("restart", n, 16);
    acc(32'hAC000000, PSI_CMD_MEM, 1'b1, 1'b0);
    chk("base", xlate.hit, 1'b0);
    acc(32'hA8000000, PSI_CMD_MEM, 1'b1, 1'b1);
    chk("other", xlate.hit, 1'b0);
    acc(32'hA8000000, PSI_CMD_IO, 1'b1, 1'b0);
    chk("space", xlate.hit, 1'b0);
    wr(PSI_SPEC_OFFSET, 32'hC05039A9);
    acc(32'hA8000000, PSI_CMD_IO, 1'b1, 1'b0);
    chk("io", {xlate.hit, xlate.posted, need_arb}, 3'b101);
    wr(PSI_SPEC_OFFSET, 32'h405039A9);
    acc(32'hA8000000, PSI_CMD_IO, 1'b1, 1'b0);
    chk("off", xlate.hit, 1'b0);
    @(posedge clk) clk_en <= 1'b0;
    wr(PSI_MISC_OFFSET, 32'h00000000);
    @(posedge clk) clk_en <= 1'b1;
    rdc(PSI_MISC_OFFSET, 32'hF1000000);
    complete_run();
  end
endmodule
